// ### pkg/bbc_pkg.sv
// shared constants and types for the backlight boost control block
package bbc_pkg;
    localparam logic [7:0] REG_STRING_ENABLE  = 8'h10;
    localparam logic [7:0] REG_BRIGHT_CTRL    = 8'h11;
    localparam logic [7:0] REG_BOOST_CTRL     = 8'h13;
    localparam logic [7:0] REG_AF_HIGH        = 8'h15;
    localparam logic [7:0] REG_AF_LOW         = 8'h16;
    localparam logic [7:0] REG_REDUCE_THR     = 8'h17;
    localparam logic [7:0] REG_BRIGHT_LOW     = 8'h18;
    localparam logic [7:0] REG_BRIGHT_HIGH    = 8'h19;
    localparam logic [7:0] REG_FAULT_SD_EN    = 8'h1E;
    localparam logic [7:0] REG_FAULT_FLAGS    = 8'h1F;
    // field positions
    localparam int BIT_DEV_EN     = 0;
    localparam int BIT_POLARITY   = 0;
    localparam int BIT_FREQ_SEL   = 5;
    localparam int BIT_MIN_IND    = 4;
    localparam int BIT_OVP_LO     = 2;
    localparam int BIT_OVP_HI     = 3;
    localparam int BIT_OVP_FLAG   = 0;
    localparam int BIT_OPEN_FLAG  = 4;
    localparam int BIT_OVP_SD     = 0;
    // reset values
    localparam logic [7:0] RST_STRING_ENABLE = 8'h07;
    localparam logic [7:0] RST_ZERO          = 8'h00;
    localparam logic [2:0] LSB_ZERO          = 3'h0;
    localparam logic [1:0] OCC_THIRD         = 2'h2;
    // timing at 250 MHz
    localparam int CLK_MHZ       = 250;
    localparam int OVP_TIME_MS   = 1;
    localparam int OVP_CYCLES    = OVP_TIME_MS * 1000 * CLK_MHZ;
    localparam int RED_TIME_US   = 50;
    localparam int RED_CYCLES    = RED_TIME_US * CLK_MHZ;
    // switching frequency codes
    typedef enum logic [1:0] {
        FREQ_250K = 2'b00,
        FREQ_500K = 2'b01,
        FREQ_1M   = 2'b10
    } bbc_freq_t;
    // overvoltage threshold codes: 17, 21, 25, 29 V
    typedef enum logic [1:0] {
        OVP_17V = 2'b00,
        OVP_21V = 2'b01,
        OVP_25V = 2'b10,
        OVP_29V = 2'b11
    } bbc_ovp_t;
    // host sequencer states
    typedef enum logic [2:0] {
        HS_IDLE  = 3'b000,
        HS_WRITE = 3'b001,
        HS_READ  = 3'b010,
        HS_WAIT  = 3'b011,
        HS_DONE  = 3'b100
    } bbc_hstate_t;
    localparam logic [31:0] AV_ZERO = 32'h0000_0000;
endpackage

// ### pkg/bbc_if.sv
// register port and pin carrier between host and boost control
`timescale 1ns/1ps
interface bbc_if;
    logic       regWrite;
    logic       regRead;
    logic [7:0] regAddr;
    logic [7:0] regWdata;
    logic [7:0] regRdata;
    logic       regAck;
    logic       backlightReduceInput;
    modport device (input regWrite, input regRead, input regAddr, input regWdata,
                    output regRdata, output regAck, input backlightReduceInput);
    modport host (output regWrite, output regRead, output regAddr, output regWdata,
                  input regRdata, input regAck, output backlightReduceInput);
endinterface

// ### hw/bbc_device.sv
// device end: frequency select, reduce override, overvoltage fault logic
//
// Decided for this implementation: register access over Avalon-MM.
`timescale 1ns/1ps
module bbc_device
    import bbc_pkg::*;
(
    input  wire logic  mclk,
    input  wire logic  reset,
    input  wire logic  clkEn,
    bbc_if.device      bus,
    input  wire logic  ovpAbove,
    input  wire logic  ovpBelowHyst,
    input  wire logic  sinkLow,
    output logic       switchEn,
    output logic [1:0] freqSel,
    output logic       dutyHalf,
    output logic [1:0] ovpThresh,
    output logic       minInductor,
    output logic [10:0] ledCode,
    output logic       deviceOn
);
    typedef struct packed {
        logic [7:0]  strEn;
        logic [7:0]  brCtl;
        logic [7:0]  boost;
        logic [7:0]  afHigh;
        logic [7:0]  afLow;
        logic [7:0]  redThr;
        logic [7:0]  brLow;
        logic [10:0] target;
        logic [7:0]  sdEn;
        logic [7:0]  flags;
        logic        shutdown;
        logic        flagsRead;
        logic [1:0]  pinSync;
        logic [1:0]  ovSync;
        logic [1:0]  hySync;
        logic [1:0]  skSync;
        logic        ovPrev;
        logic        blank;
        logic [1:0]  occCnt;
        logic [31:0] ovTime;
        logic [7:0]  rdata;
        logic        ack;
        logic        switch;
        logic [1:0]  freq;
        logic        half;
        logic [10:0] code;
    } bbc_dev_t;

    bbc_dev_t st_r;
    bbc_dev_t st_nxt;
    logic     reduceOn;
    logic     autoOn;
    logic [10:0] redCode;
    logic        ovSeen;
    logic        skSeen;
    logic        hySeen;

    always_comb
    begin
        st_nxt = st_r;
        // synchronise pins: only the second stage is read
        st_nxt.pinSync = {st_r.pinSync[0], bus.backlightReduceInput};
        st_nxt.ovSync  = {st_r.ovSync[0], ovpAbove};
        st_nxt.hySync  = {st_r.hySync[0], ovpBelowHyst};
        st_nxt.skSync  = {st_r.skSync[0], sinkLow};
        ovSeen = st_r.ovSync[1];
        hySeen = st_r.hySync[1];
        skSeen = st_r.skSync[1];
        st_nxt.ack = 1'b0;
        // register writes, one-cycle acknowledge
        if (bus.regWrite && !st_r.ack)
        begin
            st_nxt.ack = 1'b1;
            case (bus.regAddr)
                REG_STRING_ENABLE:
                begin
                    // refuse enable after fault shutdown until flags read
                    if (!(st_r.shutdown && !st_r.flagsRead))
                    begin
                        st_nxt.strEn = bus.regWdata;
                        if (bus.regWdata[BIT_DEV_EN])
                            st_nxt.shutdown = 1'b0;
                    end
                end
                REG_BRIGHT_CTRL: st_nxt.brCtl  = bus.regWdata;
                REG_BOOST_CTRL:  st_nxt.boost  = bus.regWdata;
                REG_AF_HIGH:     st_nxt.afHigh = bus.regWdata;
                REG_AF_LOW:      st_nxt.afLow  = bus.regWdata;
                REG_REDUCE_THR:  st_nxt.redThr = bus.regWdata;
                REG_BRIGHT_LOW:  st_nxt.brLow  = bus.regWdata;
                // target moves only on high byte
                REG_BRIGHT_HIGH: st_nxt.target = {bus.regWdata, st_r.brLow[2:0]};
                REG_FAULT_SD_EN: st_nxt.sdEn   = bus.regWdata;
                default: ;
            endcase
        end
        else if (bus.regRead && !st_r.ack)
        begin
            st_nxt.ack = 1'b1;
            case (bus.regAddr)
                REG_STRING_ENABLE: st_nxt.rdata = st_r.strEn;
                REG_BRIGHT_CTRL:   st_nxt.rdata = st_r.brCtl;
                REG_BOOST_CTRL:    st_nxt.rdata = st_r.boost;
                REG_AF_HIGH:       st_nxt.rdata = st_r.afHigh;
                REG_AF_LOW:        st_nxt.rdata = st_r.afLow;
                REG_REDUCE_THR:    st_nxt.rdata = st_r.redThr;
                REG_BRIGHT_LOW:    st_nxt.rdata = st_r.brLow;
                REG_BRIGHT_HIGH:   st_nxt.rdata = st_r.target[10:3];
                REG_FAULT_SD_EN:   st_nxt.rdata = st_r.sdEn;
                REG_FAULT_FLAGS:
                begin
                    // read clears flags, restarts the count, unlocks re-enable
                    st_nxt.rdata     = st_r.flags;
                    st_nxt.flags     = RST_ZERO;
                    st_nxt.flagsRead = 1'b1;
                    st_nxt.occCnt    = 2'h0;
                end
                default:           st_nxt.rdata = RST_ZERO;
            endcase
        end

        // auto frequency: any non-zero threshold enables it
        autoOn = (st_r.afHigh != RST_ZERO) || (st_r.afLow != RST_ZERO);
        if (autoOn)
        begin
            if (st_r.target[10:3] < st_r.afLow)
                st_nxt.freq = FREQ_250K;
            else if (st_r.target[10:3] >= st_r.afHigh)
                st_nxt.freq = FREQ_1M;
            else
                st_nxt.freq = FREQ_500K;
        end
        else
            // programmed bit; 250 kHz unreachable here
            st_nxt.freq = st_r.boost[BIT_FREQ_SEL] ? FREQ_1M : FREQ_500K;
        st_nxt.half = (st_nxt.freq == FREQ_250K);

        // reduce override, polarity bit 1 means active low
        reduceOn = st_r.pinSync[1] ^ st_r.brCtl[BIT_POLARITY];
        redCode  = {st_r.redThr, LSB_ZERO};
        // applied next cycle, far inside the 50 us bound
        if (reduceOn && redCode < st_r.target)
            st_nxt.code = redCode;
        else
            st_nxt.code = st_r.target;

        // overvoltage: stop switching, resume below hysteresis
        if (ovSeen)
            st_nxt.blank = 1'b1;
        else if (hySeen)
            st_nxt.blank = 1'b0;
        st_nxt.ovPrev = ovSeen;
        st_nxt.ovTime = ovSeen ? st_r.ovTime + 32'h1 : AV_ZERO;
        if (ovSeen && !st_r.ovPrev && skSeen && st_r.occCnt != OCC_THIRD + 2'h1)
            st_nxt.occCnt = st_r.occCnt + 2'h1;
        if (ovSeen && !st_r.ovPrev && skSeen && st_r.occCnt == OCC_THIRD)
        begin
            st_nxt.flags[BIT_OVP_FLAG]  = 1'b1;
            st_nxt.flags[BIT_OPEN_FLAG] = 1'b1;
        end
        if (st_r.ovTime >= OVP_CYCLES)
        begin
            st_nxt.flags[BIT_OVP_FLAG] = 1'b1;
            if (skSeen)
                st_nxt.flags[BIT_OPEN_FLAG] = 1'b1;
        end
        // shutdown only when enabled; otherwise report
        if (st_nxt.flags[BIT_OVP_FLAG] && st_r.sdEn[BIT_OVP_SD] && !st_r.shutdown)
        begin
            st_nxt.shutdown  = 1'b1;
            st_nxt.flagsRead = 1'b0;
            st_nxt.strEn[BIT_DEV_EN] = 1'b0;
            st_nxt.occCnt = 2'h0;
        end
        st_nxt.switch = st_nxt.strEn[BIT_DEV_EN] && !st_nxt.blank && !st_nxt.shutdown;
    end

    // single state register; clock enable freezes everything
    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            st_r       <= '0;
            st_r.strEn <= RST_STRING_ENABLE;
        end
        else if (clkEn)
            st_r <= st_nxt;
    end

    assign bus.regRdata = st_r.rdata;
    assign bus.regAck   = st_r.ack;
    assign switchEn     = st_r.switch;
    assign freqSel      = st_r.freq;
    assign dutyHalf     = st_r.half;
    assign ovpThresh    = st_r.boost[BIT_OVP_HI:BIT_OVP_LO];
    assign minInductor  = st_r.boost[BIT_MIN_IND];
    assign ledCode      = st_r.code;
    assign deviceOn     = st_r.strEn[BIT_DEV_EN];
endmodule

// ### hw/bbc_host.sv
// host end: Avalon-MM slave turning software orders into register cycles
`timescale 1ns/1ps
module bbc_host
    import bbc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        reset,
    input  wire logic        clkEn,
    bbc_if.host              dev,
    input  wire logic [3:0]  avAddress,
    input  wire logic        avRead,
    input  wire logic        avWrite,
    input  wire logic [31:0] avWritedata,
    output logic [31:0]      avReaddata,
    output logic             avWaitrequest
);
    // word 4 has no device reg, so it holds the reduce pin and word 0 reaches enable
    localparam logic [3:0] AV_PIN = 4'h4;
    localparam logic [3:0] REG_BASE_HI = 4'h1;

    typedef struct packed {
        bbc_hstate_t st;
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [7:0]  wdata;
        logic        pin;
        logic [31:0] rdata;
        logic        waitReq;
    } bbc_host_t;

    bbc_host_t h_r;
    bbc_host_t h_nxt;

    always_comb
    begin
        h_nxt = h_r;
        h_nxt.waitReq = 1'b1;
        case (h_r.st)
            HS_IDLE:
            begin
                if ((avWrite || avRead) && avAddress == AV_PIN)
                begin
                    if (avWrite)
                        h_nxt.pin = avWritedata[0];
                    h_nxt.rdata  = {31'h0, h_r.pin};
                    h_nxt.waitReq = 1'b0;
                    h_nxt.st     = HS_DONE;
                end
                else if (avWrite || avRead)
                begin
                    // order sequence such as the open-string test is software's
                    h_nxt.addr  = {REG_BASE_HI, avAddress};
                    h_nxt.wdata = avWritedata[7:0];
                    h_nxt.wr    = avWrite;
                    h_nxt.rd    = avRead;
                    h_nxt.st    = HS_WAIT;
                end
            end
            HS_WAIT:
            begin
                if (dev.regAck)
                begin
                    h_nxt.wr     = 1'b0;
                    h_nxt.rd     = 1'b0;
                    h_nxt.rdata  = {24'h0, dev.regRdata};
                    h_nxt.waitReq = 1'b0;
                    h_nxt.st     = HS_DONE;
                end
            end
            HS_DONE: h_nxt.st = HS_IDLE; // waitrequest low for this cycle
            default: h_nxt.st = HS_IDLE;
        endcase
    end

    always_ff @(posedge mclk)
    begin
        if (reset)
        begin
            h_r         <= '0;
            h_r.waitReq <= 1'b1;
        end
        else if (clkEn)
            h_r <= h_nxt;
    end

    assign dev.regWrite             = h_r.wr;
    assign dev.regRead              = h_r.rd;
    assign dev.regAddr              = h_r.addr;
    assign dev.regWdata             = h_r.wdata;
    assign dev.backlightReduceInput = h_r.pin;
    assign avReaddata               = h_r.rdata;
    assign avWaitrequest            = h_r.waitReq;
endmodule

// ### tb/bbc_chk.sv
// concurrent checks on the host/device link and the device outputs
`timescale 1ns/1ps
module bbc_chk
    import bbc_pkg::*;
(
    input wire logic        mclk,
    input wire logic        reset,
    input wire logic        regWrite,
    input wire logic        regRead,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWdata,
    input wire logic [7:0]  regRdata,
    input wire logic        regAck,
    input wire logic        backlightReduceInput,
    input wire logic        ovpAbove,
    input wire logic        ovpBelowHyst,
    input wire logic        switchEn,
    input wire logic [1:0]  freqSel,
    input wire logic        dutyHalf,
    input wire logic [1:0]  ovpThresh,
    input wire logic        minInductor,
    input wire logic [10:0] ledCode,
    input wire logic        deviceOn
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    // link answer one cycle after take, then request and ack drop together
    property p_ack_next; (regWrite || regRead) && !regAck |=> regAck; endproperty
    a_ack_next: assert property (p_ack_next) else $error("link answer late");
    property p_req_drop; regAck |=> !regAck && !regWrite && !regRead; endproperty
    a_req_drop: assert property (p_req_drop) else $error("link request held");
    // guarded one edge after reset, when registers still show reset values
    property p_duty; !$past(reset) |-> dutyHalf == (freqSel == FREQ_250K); endproperty
    a_duty: assert property (p_duty) else $error("duty limit wrong");
    property p_ovp_stop; ovpAbove [*4] |=> !switchEn; endproperty
    a_ovp_stop: assert property (p_ovp_stop) else $error("switching not stopped");
    property p_ovp_go; (!ovpAbove && ovpBelowHyst && deviceOn) [*4] |=> switchEn; endproperty
    a_ovp_go: assert property (p_ovp_go) else $error("switching not resumed");
    property p_boost;
        regAck && regWrite && regAddr == REG_BOOST_CTRL |->
            ovpThresh == regWdata[BIT_OVP_HI:BIT_OVP_LO]
            && minInductor == regWdata[BIT_MIN_IND];
    endproperty
    a_boost: assert property (p_boost) else $error("boost field wrong");
    property p_low_byte;
        regAck && regWrite && regAddr == REG_BRIGHT_LOW && $stable(backlightReduceInput)
            |=> $stable(ledCode) [*3];
    endproperty
    a_low_byte: assert property (p_low_byte) else $error("low byte moved code");
    property p_flags;
        regAck && regRead && regAddr == REG_FAULT_FLAGS && regRdata[BIT_OPEN_FLAG]
            |-> regRdata[BIT_OVP_FLAG];
    endproperty
    a_flags: assert property (p_flags) else $error("open flag alone");
    property p_no_code; freqSel != 2'h3; endproperty
    a_no_code: assert property (p_no_code) else $error("bad frequency code");
    c_high: cover property (regAck && regWrite && regAddr == REG_BRIGHT_HIGH);
    c_low_freq: cover property (freqSel == FREQ_250K);
    c_off: cover property (!deviceOn);
endmodule

// ### tb/backlight_boost_control_tb.sv
// self-checking bench joining the host and device ends
`timescale 1ns/1ps
module backlight_boost_control_tb;
    import bbc_pkg::*;
    logic        mclk;
    logic        reset;
    logic        clkEn;
    logic [3:0]  avAddress;
    logic        avRead;
    logic        avWrite;
    logic [31:0] avWritedata;
    logic [31:0] avReaddata;
    logic        avWaitrequest;
    logic        ovpAbove;
    logic        ovpBelowHyst;
    logic        sinkLow;
    logic        switchEn;
    logic [1:0]  freqSel;
    logic        dutyHalf;
    logic [1:0]  ovpThresh;
    logic        minInductor;
    logic [10:0] ledCode;
    logic        deviceOn;
    logic [7:0]  rd;
    int          numErrors;
    int          comparisons;
    bbc_if bbc_if_i ();
    bbc_host bbc_host_i (.mclk(mclk), .reset(reset), .clkEn(clkEn), .dev(bbc_if_i),
        .avAddress(avAddress), .avRead(avRead), .avWrite(avWrite),
        .avWritedata(avWritedata), .avReaddata(avReaddata), .avWaitrequest(avWaitrequest));
    bbc_device bbc_device_i (.mclk(mclk), .reset(reset), .clkEn(clkEn), .bus(bbc_if_i),
        .ovpAbove(ovpAbove), .ovpBelowHyst(ovpBelowHyst), .sinkLow(sinkLow),
        .switchEn(switchEn), .freqSel(freqSel), .dutyHalf(dutyHalf), .ovpThresh(ovpThresh),
        .minInductor(minInductor), .ledCode(ledCode), .deviceOn(deviceOn));
    bbc_chk bbc_chk_i (.mclk(mclk), .reset(reset), .regWrite(bbc_if_i.regWrite),
        .regRead(bbc_if_i.regRead), .regAddr(bbc_if_i.regAddr), .regWdata(bbc_if_i.regWdata),
        .regRdata(bbc_if_i.regRdata), .regAck(bbc_if_i.regAck),
        .backlightReduceInput(bbc_if_i.backlightReduceInput), .ovpAbove(ovpAbove),
        .ovpBelowHyst(ovpBelowHyst), .switchEn(switchEn), .freqSel(freqSel),
        .dutyHalf(dutyHalf), .ovpThresh(ovpThresh), .minInductor(minInductor),
        .ledCode(ledCode), .deviceOn(deviceOn));
    task automatic finishTest();
        $display("comparisons %0d mismatches %0d", comparisons, numErrors);
        if (numErrors == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            numErrors++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // settle on falling edges so registered outputs are never raced
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    // one avalon cycle, held until waitrequest is seen low at a rising edge
    task automatic av(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        avAddress   <= a;
        avWritedata <= {24'h000000, d};
        avWrite     <= wr;
        avRead      <= !wr;
        // only the watchdog ends a wait; data is taken at the answering edge
        do
        begin
            @(posedge mclk);
        end
        while (avWaitrequest !== 1'h0);
        rd = avReaddata[7:0];
        avWrite <= 1'h0;
        avRead  <= 1'h0;
    endtask
    // manual frequency: every overvoltage code, inductor and frequency bits
    task automatic t_boost();
        for (int i = 0; i < 4; i++)
        begin
            av(1'h1, 4'h3, {2'h0, i[0], i[0], i[1:0], 2'h0});
            cyc(3);
            chk(ovpThresh, i[1:0]);
            chk(minInductor, i[0]);
            chk(freqSel, i[0] ? FREQ_1M : FREQ_500K);
            chk(dutyHalf, 1'h0);
            av(1'h0, 4'h3, 8'h00);
            chk(rd, {2'h0, i[0], i[0], i[1:0], 2'h0});
        end
        $display("test boost done");
    endtask
    // threshold boundaries, then disabling auto one register at a time
    task automatic t_auto();
        logic [7:0] b [5] = '{8'h1F, 8'h20, 8'h7F, 8'h80, 8'hFF};
        bbc_freq_t  f [5] = '{FREQ_250K, FREQ_500K, FREQ_500K, FREQ_1M, FREQ_1M};
        av(1'h1, 4'h5, 8'h80);
        av(1'h1, 4'h6, 8'h20);
        for (int k = 0; k < 5; k++)
        begin
            av(1'h1, 4'h9, b[k]);
            cyc(3);
            chk(freqSel, f[k]);
            chk(dutyHalf, f[k] == FREQ_250K);
        end
        av(1'h1, 4'h9, 8'h10);
        av(1'h1, 4'h5, 8'h00);
        cyc(3);
        chk(freqSel, FREQ_250K);
        av(1'h1, 4'h6, 8'h00);
        cyc(3);
        chk(freqSel, FREQ_1M);
        $display("test auto done");
    endtask
    // reduce override both polarities, and a threshold above the target
    task automatic t_reduce();
        av(1'h1, 4'h8, 8'h07);
        cyc(4);
        chk(ledCode, 11'h080);
        av(1'h1, 4'h9, 8'hF0);
        av(1'h1, 4'h7, 8'h40);
        av(1'h1, 4'h4, 8'h01);
        cyc(6);
        chk(ledCode, 11'h200);
        av(1'h1, 4'h4, 8'h00);
        cyc(6);
        chk(ledCode, 11'h787);
        av(1'h1, 4'h1, 8'h01);
        cyc(6);
        chk(ledCode, 11'h200);
        av(1'h1, 4'h4, 8'h01);
        av(1'h1, 4'h7, 8'hF8);
        av(1'h1, 4'h4, 8'h00);
        cyc(6);
        chk(ledCode, 11'h787);
        av(1'h1, 4'h1, 8'h00);
        $display("test reduce done");
    endtask
    // short excursion: stop, hold until below hysteresis, no flag
    task automatic t_hyst();
        @(posedge mclk);
        ovpAbove     <= 1'h1;
        ovpBelowHyst <= 1'h0;
        cyc(6);
        chk(switchEn, 1'h0);
        @(posedge mclk);
        ovpAbove <= 1'h0;
        cyc(6);
        chk(switchEn, 1'h0);
        @(posedge mclk);
        ovpBelowHyst <= 1'h1;
        cyc(6);
        chk(switchEn, 1'h1);
        av(1'h0, 4'hF, 8'h00);
        chk(rd, 8'h00);
        $display("test hysteresis done");
    endtask
    task automatic pulses();
        @(posedge mclk);
        sinkLow <= 1'h1;
        repeat (3)
        begin
            @(posedge mclk);
            ovpAbove     <= 1'h1;
            ovpBelowHyst <= 1'h0;
            cyc(6);
            @(posedge mclk);
            ovpAbove     <= 1'h0;
            ovpBelowHyst <= 1'h1;
            cyc(6);
        end
    endtask
    // open string: report only, read clears, then shutdown enabled
    task automatic t_open();
        pulses();
        chk(deviceOn, 1'h1);
        av(1'h0, 4'hF, 8'h00);
        chk(rd[BIT_OVP_FLAG], 1'h1);
        chk(rd[BIT_OPEN_FLAG], 1'h1);
        av(1'h0, 4'hF, 8'h00);
        chk(rd, 8'h00);
        av(1'h1, 4'hE, 8'h01);
        pulses();
        cyc(4);
        chk(deviceOn, 1'h0);
        chk(switchEn, 1'h0);
        av(1'h1, 4'h0, 8'h07);
        cyc(2);
        chk(deviceOn, 1'h0);
        av(1'h0, 4'hF, 8'h00);
        chk(rd, 8'h11);
        av(1'h1, 4'h0, 8'h07);
        cyc(2);
        chk(deviceOn, 1'h1);
        $display("test open done");
    endtask
    initial
    begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    // watchdog far beyond the few hundred cycles the tests need
    initial
    begin
        repeat (50000) @(posedge mclk);
        numErrors++;
        finishTest();
    end
    initial
    begin
        numErrors = 0;
        comparisons = 0;
        reset = 1'h1;
        clkEn = 1'h1;
        avAddress = 4'h0;
        avRead = 1'h0;
        avWrite = 1'h0;
        avWritedata = 32'h00000000;
        ovpAbove = 1'h0;
        ovpBelowHyst = 1'h1;
        sinkLow = 1'h0;
        repeat (4) @(posedge mclk);
        reset <= 1'h0;
        t_boost();
        t_auto();
        t_reduce();
        t_hyst();
        t_open();
        finishTest();
    end
endmodule
